//--- fmac_cfg.svh
// constants for the flash access control block
`ifndef FMAC_CFG_SVH
`define FMAC_CFG_SVH
`define FMAC_CMD_READ 8'h01
`define FMAC_CMD_WRITE 8'h02
`define FMAC_CMD_VERIFY 8'h04
`define FMAC_CMD_ERASE_PAGE 8'h05
`define FMAC_CMD_ERASE_ALL 8'h06
`define FMAC_CMD_READ_BYTE 8'h81
`define FMAC_CMD_WRITE_BYTE 8'h82
`define FMAC_CMD_LEAVE_ULD 8'h0F
`define FMAC_CMD_ENTER_ULD 8'hF0
`define FMAC_DATA_PAGES 1024
`define FMAC_PAGE_BYTES 4
`define FMAC_ULD_LIMIT 16'hE000
`define FMAC_FLASH_LIMIT 16'hF800
`define FMAC_BOOT_VECTOR 16'hE000
`define FMAC_ERASED 8'hFF
`define FMAC_VERIFY_BAD 8'h01
`endif

//--- fmac_pkg.sv
// types for the flash access control block
package fmac_pkg;
  typedef enum logic [1:0] {
    FMAC_IDLE = 2'b00,
    FMAC_EXEC = 2'b01
  } fmac_state_t;
  typedef enum logic [1:0] {
    FMAC_SRC_CORE = 2'b00,
    FMAC_SRC_SERIAL = 2'b01,
    FMAC_SRC_PARALLEL = 2'b11
  } fmac_src_t;
endpackage

//--- fmac_prog_array.sv
// program flash array with byte write and range erase
`timescale 1ns/1ns
module fmac_prog_array
  import fmac_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DEPTH = 63488
) (
  input wire logic ref_clk_i,
  input wire logic clk_en_i,
  input wire logic wr_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic erase_i,
  input wire logic [ADDR_W-1:0] erase_lo_i,
  input wire logic [ADDR_W-1:0] erase_hi_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  `include "fmac_cfg.svh"
  logic [7:0] mem [0:DEPTH-1];
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      if (erase_i) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (i >= int'(erase_lo_i) && i <= int'(erase_hi_i)) begin
            mem[i] <= `FMAC_ERASED;
          end
        end
      end else if (wr_i && int'(wr_addr_i) < DEPTH) begin
        mem[wr_addr_i] <= mem[wr_addr_i] & wr_data_i;
      end
    end
  end
  // combinational read, registered once by the caller
  assign rd_data_o = (int'(rd_addr_i) < DEPTH) ? mem[rd_addr_i] : `FMAC_ERASED;
endmodule

//--- fmac_top.sv
// flash access control: data flash, program flash guard, security modes
// Operation
// - data flash is 1024 pages of four bytes
// - four page data registers hold one page
// - page chosen by high and low address registers
// - 8-bit command register, nine command codes trigger operations
// - one command register serves data and program flash by mode
// - program flash fills lowest 62k of 64k code space
// - without user download mode program flash is read only
// - user download mode allows erase and write of lowest 56k
// - top 6k writable only by serial or parallel programming
// - strobe low at reset release enters serial download
// - serial download writes all of program flash
// - parallel ports form address and data bus, prog_wr_i is write enable
// - three security modes set only by serial or parallel programming
// - lock mode refuses parallel programming, reads still allowed
// - secure mode blocks parallel program, read and external code reads
// - lock and secure cleared only by code erase, serial or parallel
// - serial safe mode turns download reset into normal reset
// - serial safe cleared only by parallel code erase
// - boot option starts execution at E000h after reset
// - decode read, write, verify, erase, erase all, byte read, write
// - verify result: command register reads zero on match
// - F0h selects program flash, 0Fh returns to data flash
`timescale 1ns/1ns
module fmac_top
  import fmac_pkg::*;
#(
  parameter int PAGES = 1024,
  parameter int PROG_DEPTH = 63488
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // core register access
  input wire logic sfr_wr_i,
  input wire logic [2:0] sfr_sel_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic ext_exec_i,
  // code reads from the core
  input wire logic code_rd_i,
  input wire logic [15:0] code_addr_i,
  output logic [7:0] code_data_o,
  output logic code_block_o,
  // pins sampled at reset release
  input wire logic program_store_strobe_n_i,
  input wire logic boot_option_i,
  // serial download and parallel programming ports
  input wire logic prog_wr_i,
  input wire logic prog_rd_i,
  input wire logic [1:0] prog_src_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic [7:0] prog_wdata_i,
  input wire logic prog_code_erase_i,
  input wire logic [2:0] prog_sec_set_i,
  output logic [7:0] prog_rdata_o,
  output logic prog_refused_o,
  // mode outputs
  output logic serial_download_o,
  output logic user_download_mode_o,
  output logic [15:0] reset_vector_o,
  output logic lock_mode_o,
  output logic secure_mode_o,
  output logic serial_safe_o
);
  `include "fmac_cfg.svh"
  localparam int DW = $clog2(PAGES * `FMAC_PAGE_BYTES);

  //----------------------------------------------------------------
  // register selects
  //----------------------------------------------------------------
  localparam logic [2:0] SEL_CMD = 3'h0;
  localparam logic [2:0] SEL_D1 = 3'h1;
  localparam logic [2:0] SEL_D4 = 3'h4;
  localparam logic [2:0] SEL_AH = 3'h5;
  localparam logic [2:0] SEL_AL = 3'h6;

  typedef struct packed {
    fmac_state_t st;
    logic [7:0] cmd;
    logic [3:0][7:0] page;
    logic [7:0] addr_h;
    logic [7:0] addr_l;
    logic uld;
    logic sdl;
    logic lock;
    logic secure;
    logic safe;
    logic boot;
    logic seen_reset;
    logic [7:0] prd;
  } fmac_state_s_t;

  fmac_state_s_t s_r;
  fmac_state_s_t s_nxt;

  logic [7:0] dmem [0:PAGES*`FMAC_PAGE_BYTES-1];

  function automatic logic [DW-1:0] byte_addr(input logic [15:0] a);
    return a[DW-1:0];
  endfunction

  function automatic logic uld_writable(input logic [15:0] a);
    return a < `FMAC_ULD_LIMIT;
  endfunction

  logic [15:0] ea;
  logic [DW-1:0] pbase;
  assign ea = {s_r.addr_h, s_r.addr_l};
  assign pbase = byte_addr({ea[13:0], 2'b00});

  //----------------------------------------------------------------
  // program flash write and erase control
  //----------------------------------------------------------------
  logic pf_wr;
  logic [15:0] pf_wa;
  logic [7:0] pf_wd;
  logic pf_er;
  logic [15:0] pf_lo;
  logic [15:0] pf_hi;
  logic [15:0] pf_ra;
  logic [7:0] pf_rd;
  logic core_cmd;
  logic p_par;
  logic p_ok;

  assign core_cmd = sfr_wr_i && sfr_sel_i == SEL_CMD && s_r.st == FMAC_IDLE;
  assign p_par = prog_src_i == FMAC_SRC_PARALLEL;
  // lock refuses parallel writes, secure refuses parallel reads and writes
  assign p_ok = !(p_par && (s_r.lock || s_r.secure));
  assign prog_refused_o = p_par && (prog_wr_i ? !p_ok : (prog_rd_i && s_r.secure));

  always_comb begin
    pf_wr = 1'b0;
    pf_wa = prog_addr_i;
    pf_wd = prog_wdata_i;
    pf_er = 1'b0;
    pf_lo = 16'h0000;
    pf_hi = 16'h0000;
    if ((s_r.sdl || p_par) && prog_wr_i && p_ok) begin
      pf_wr = prog_addr_i < `FMAC_FLASH_LIMIT;
    end else if ((s_r.sdl || p_par) && prog_code_erase_i) begin
      pf_er = 1'b1;
      pf_hi = `FMAC_FLASH_LIMIT - 16'h0001;
    end else if (core_cmd && s_r.uld) begin
      case (sfr_wdata_i)
        `FMAC_CMD_WRITE_BYTE: begin
          pf_wr = uld_writable(ea);
          pf_wa = ea;
          pf_wd = s_r.page[0];
        end
        `FMAC_CMD_ERASE_PAGE: begin
          pf_er = uld_writable(ea);
          pf_lo = {ea[15:6], 6'h00};
          pf_hi = {ea[15:6], 6'h3F};
        end
        `FMAC_CMD_ERASE_ALL: begin
          pf_er = 1'b1;
          pf_hi = `FMAC_ULD_LIMIT - 16'h0001;
        end
        default: pf_er = 1'b0;
      endcase
    end
  end

  assign pf_ra = prog_rd_i ? prog_addr_i : code_addr_i;
  // external code may not read internal code in secure mode
  assign code_block_o = code_rd_i && ext_exec_i && s_r.secure;

  fmac_prog_array #(
    .ADDR_W(16),
    .DEPTH(PROG_DEPTH)
  ) u_prog (
    .ref_clk_i(ref_clk_i),
    .clk_en_i(clk_en_i),
    .wr_i(pf_wr),
    .wr_addr_i(pf_wa),
    .wr_data_i(pf_wd),
    .erase_i(pf_er),
    .erase_lo_i(pf_lo),
    .erase_hi_i(pf_hi),
    .rd_addr_i(pf_ra),
    .rd_data_o(pf_rd)
  );

  //----------------------------------------------------------------
  // next state
  //----------------------------------------------------------------
  logic dm_blk;
  assign dm_blk = ext_exec_i && s_r.secure;

  always_comb begin
    s_nxt = s_r;
    s_nxt.prd = (p_par && s_r.secure) ? 8'h00 : pf_rd;
    if (!s_r.seen_reset) begin
      s_nxt.seen_reset = 1'b1;
      s_nxt.sdl = !program_store_strobe_n_i && !s_r.safe;
      s_nxt.boot = boot_option_i;
    end
    if (prog_code_erase_i && (s_r.sdl || p_par)) begin
      s_nxt.lock = 1'b0;
      s_nxt.secure = 1'b0;
      if (p_par) begin
        s_nxt.safe = 1'b0;
      end
    end
    if (s_r.sdl || p_par) begin
      s_nxt.lock = s_nxt.lock | prog_sec_set_i[0];
      s_nxt.secure = s_nxt.secure | prog_sec_set_i[1];
      s_nxt.safe = s_nxt.safe | prog_sec_set_i[2];
    end
    case (s_r.st)
      FMAC_IDLE: begin
        if (sfr_wr_i && !dm_blk) begin
          case (sfr_sel_i)
            SEL_CMD: begin
              s_nxt.cmd = sfr_wdata_i;
              s_nxt.st = FMAC_EXEC;
            end
            SEL_AH: s_nxt.addr_h = sfr_wdata_i;
            SEL_AL: s_nxt.addr_l = sfr_wdata_i;
            default: begin
              if (sfr_sel_i >= SEL_D1 && sfr_sel_i <= SEL_D4) begin
                s_nxt.page[sfr_sel_i[1:0] - 2'd1] = sfr_wdata_i;
              end
            end
          endcase
        end
      end
      FMAC_EXEC: begin
        s_nxt.st = FMAC_IDLE;
        case (s_r.cmd)
          `FMAC_CMD_ENTER_ULD: s_nxt.uld = 1'b1;
          `FMAC_CMD_LEAVE_ULD: s_nxt.uld = 1'b0;
          `FMAC_CMD_READ: begin
            if (!s_r.uld) begin
              for (int i = 0; i < 4; i++) begin
                s_nxt.page[i] = dmem[pbase + DW'(i)];
              end
            end
          end
          `FMAC_CMD_READ_BYTE: begin
            if (!s_r.uld) begin
              s_nxt.page[0] = dmem[byte_addr(ea)];
            end
          end
          `FMAC_CMD_VERIFY: begin
            if (!s_r.uld) begin
              s_nxt.cmd = 8'h00;
              for (int i = 0; i < 4; i++) begin
                if (dmem[pbase + DW'(i)] != s_r.page[i]) begin
                  s_nxt.cmd = `FMAC_VERIFY_BAD;
                end
              end
            end
          end
          default: s_nxt.cmd = s_r.cmd;
        endcase
      end
      default: s_nxt.st = FMAC_IDLE;
    endcase
  end

  //----------------------------------------------------------------
  // data flash array
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i && s_r.st == FMAC_EXEC && !s_r.uld) begin
      case (s_r.cmd)
        `FMAC_CMD_WRITE: begin
          for (int i = 0; i < 4; i++) begin
            dmem[pbase + DW'(i)] <= dmem[pbase + DW'(i)] & s_r.page[i];
          end
        end
        `FMAC_CMD_WRITE_BYTE: dmem[byte_addr(ea)] <= dmem[byte_addr(ea)] & s_r.page[0];
        `FMAC_CMD_ERASE_PAGE: begin
          for (int i = 0; i < 4; i++) begin
            dmem[pbase + DW'(i)] <= `FMAC_ERASED;
          end
        end
        `FMAC_CMD_ERASE_ALL: begin
          for (int i = 0; i < PAGES * `FMAC_PAGE_BYTES; i++) begin
            dmem[i] <= `FMAC_ERASED;
          end
        end
        default: ;
      endcase
    end
  end

  // security bits are nonvolatile: kept through reset, cleared by code erase
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_r.st <= FMAC_IDLE;
      s_r.cmd <= 8'h00;
      s_r.page <= '0;
      s_r.addr_h <= 8'h00;
      s_r.addr_l <= 8'h00;
      s_r.uld <= 1'b0;
      s_r.sdl <= 1'b0;
      s_r.boot <= 1'b0;
      s_r.seen_reset <= 1'b0;
      s_r.prd <= 8'h00;
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

  //----------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------
  always_comb begin
    case (sfr_sel_i)
      SEL_CMD: sfr_rdata_o = s_r.cmd;
      SEL_AH: sfr_rdata_o = s_r.addr_h;
      SEL_AL: sfr_rdata_o = s_r.addr_l;
      default: sfr_rdata_o = (sfr_sel_i >= SEL_D1 && sfr_sel_i <= SEL_D4)
                             ? s_r.page[sfr_sel_i[1:0] - 2'd1] : 8'h00;
    endcase
  end

  assign code_data_o = s_r.prd;
  assign prog_rdata_o = s_r.prd;
  assign serial_download_o = s_r.sdl;
  assign user_download_mode_o = s_r.uld;
  assign reset_vector_o = s_r.boot ? `FMAC_BOOT_VECTOR : 16'h0000;
  assign lock_mode_o = s_r.lock;
  assign secure_mode_o = s_r.secure;
  assign serial_safe_o = s_r.safe;

  //----------------------------------------------------------------
  // checks
  //----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  cmd_launch_a: assert property (clk_en_i && core_cmd |=> s_r.st == FMAC_EXEC)
    else $error("command not launched");
  uld_enter_a: assert property (clk_en_i && s_r.st == FMAC_EXEC && s_r.cmd == `FMAC_CMD_ENTER_ULD
    |=> user_download_mode_o)
    else $error("user download not entered");
  uld_leave_a: assert property (clk_en_i && s_r.st == FMAC_EXEC && s_r.cmd == `FMAC_CMD_LEAVE_ULD
    |=> !user_download_mode_o)
    else $error("user download not left");
  boot_guard_a: assert property (pf_wr && !s_r.sdl && !p_par |-> pf_wa < `FMAC_ULD_LIMIT)
    else $error("protected region written");
  ro_guard_a: assert property (!s_r.uld && !s_r.sdl && !p_par |-> !pf_wr && !pf_er)
    else $error("program flash changed outside download");
  lock_guard_a: assert property (p_par && (s_r.lock || s_r.secure) && prog_wr_i |-> !pf_wr)
    else $error("locked part programmed");
  secure_read_a: assert property (clk_en_i && p_par && s_r.secure |=> prog_rdata_o == 8'h00)
    else $error("secure part read");
  safe_hold_a: assert property (clk_en_i && s_r.safe && !s_r.seen_reset |=> !serial_download_o)
    else $error("download entered in safe mode");
  safe_keep_a: assert property (clk_en_i && s_r.safe && !p_par |=> serial_safe_o)
    else $error("serial safe cleared");
  bad_cmd_a: assert property (clk_en_i && s_r.st == FMAC_EXEC && s_r.cmd == 8'h03
    |=> $stable(s_r.page))
    else $error("reserved code changed data");

  verify_c: cover property (s_r.st == FMAC_EXEC && s_r.cmd == `FMAC_CMD_VERIFY);
  uld_c: cover property (user_download_mode_o && pf_er);
  sdl_c: cover property (serial_download_o);
  par_c: cover property (p_par && prog_code_erase_i);
endmodule

//--- fmac_prog_host.sv
// model of the external programmer and serial download host
`timescale 1ns/1ns
module fmac_prog_host (
  input wire logic ref_clk_i,
  input wire logic [7:0] prog_rdata_i,
  input wire logic prog_refused_i,
  output logic strobe_n_o,
  output logic prog_wr_o,
  output logic prog_rd_o,
  output logic [1:0] prog_src_o,
  output logic [15:0] prog_addr_o,
  output logic [7:0] prog_wdata_o,
  output logic prog_code_erase_o,
  output logic [2:0] prog_sec_set_o
);
  initial begin
    strobe_n_o = 1'b1;
    prog_wr_o = 1'b0;
    prog_rd_o = 1'b0;
    prog_src_o = 2'b00;
    prog_addr_o = 16'h0000;
    prog_wdata_o = 8'h00;
    prog_code_erase_o = 1'b0;
    prog_sec_set_o = 3'b000;
  end

  // strap pin held through reset
  task automatic strap(input logic level);
    @(posedge ref_clk_i);
    strobe_n_o <= level;
  endtask

  // one byte transfer; kind is {security set, code erase, read, write}
  task automatic op(input logic [1:0] src, input logic [5:0] kind, input logic [15:0] addr,
                    input logic [7:0] data, output logic refused, output logic [7:0] rdata);
    @(posedge ref_clk_i);
    prog_src_o <= src;
    prog_addr_o <= addr;
    prog_wdata_o <= data;
    prog_wr_o <= kind[0];
    prog_rd_o <= kind[1];
    prog_code_erase_o <= kind[2];
    prog_sec_set_o <= kind[5:3];
    #1;
    refused = prog_refused_i;
    @(posedge ref_clk_i);
    prog_wr_o <= 1'b0;
    prog_rd_o <= 1'b0;
    prog_code_erase_o <= 1'b0;
    prog_sec_set_o <= 3'b000;
    prog_src_o <= 2'b00;
    // released bus no longer shows the last value
    prog_addr_o <= ~addr;
    prog_wdata_o <= ~data;
    #1;
    rdata = prog_rdata_i;
  endtask
endmodule

//--- flash_memory_access_control_test.sv
// self-checking bench for the flash access control block
`timescale 1ns/1ns
`include "fmac_cfg.svh"
module flash_memory_access_control_test;
  logic ref_clk_i, reset_i, clk_en_i, sfr_wr_i, ext_exec_i, code_rd_i, boot_option_i;
  logic [2:0] sfr_sel_i, prog_sec_set_i;
  logic [7:0] sfr_wdata_i, sfr_rdata_o, code_data_o, prog_wdata_i, prog_rdata_o, rdv;
  logic [15:0] code_addr_i, prog_addr_i, reset_vector_o;
  logic [1:0] prog_src_i;
  logic code_block_o, program_store_strobe_n_i, prog_wr_i, prog_rd_i, prog_code_erase_i;
  logic prog_refused_o, serial_download_o, user_download_mode_o, rf;
  logic lock_mode_o, secure_mode_o, serial_safe_o;
  int error_cnt = 0;
  int compares = 0;

  fmac_top dut (.ref_clk_i, .reset_i, .clk_en_i, .sfr_wr_i, .sfr_sel_i, .sfr_wdata_i,
    .sfr_rdata_o, .ext_exec_i, .code_rd_i, .code_addr_i, .code_data_o, .code_block_o,
    .program_store_strobe_n_i, .boot_option_i, .prog_wr_i, .prog_rd_i, .prog_src_i,
    .prog_addr_i, .prog_wdata_i, .prog_code_erase_i, .prog_sec_set_i, .prog_rdata_o,
    .prog_refused_o, .serial_download_o, .user_download_mode_o, .reset_vector_o,
    .lock_mode_o, .secure_mode_o, .serial_safe_o);

  fmac_prog_host host (.ref_clk_i, .prog_rdata_i(prog_rdata_o), .prog_refused_i(prog_refused_o),
    .strobe_n_o(program_store_strobe_n_i), .prog_wr_o(prog_wr_i), .prog_rd_o(prog_rd_i),
    .prog_src_o(prog_src_i), .prog_addr_o(prog_addr_i), .prog_wdata_o(prog_wdata_i),
    .prog_code_erase_o(prog_code_erase_i), .prog_sec_set_o(prog_sec_set_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report;
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b1;
    sfr_sel_i <= sel;
    sfr_wdata_i <= d;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
    sfr_wdata_i <= ~d;
    repeat (2) @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
    @(posedge ref_clk_i);
    sfr_sel_i <= sel;
    #1;
    chk(16'(sfr_rdata_o), 16'(exp));
  endtask

  task automatic page(input logic [15:0] a);
    wr(3'd5, a[15:8]);
    wr(3'd6, a[7:0]);
  endtask

  task automatic crd(input logic [15:0] a, input logic ext, input logic [7:0] exp,
                     input logic blk);
    @(posedge ref_clk_i);
    code_rd_i <= 1'b1;
    code_addr_i <= a;
    ext_exec_i <= ext;
    #1;
    chk(16'(code_block_o), 16'(blk));
    @(posedge ref_clk_i);
    code_rd_i <= 1'b0;
    ext_exec_i <= 1'b0;
    code_addr_i <= ~a;
    #1;
    if (!blk) chk(16'(code_data_o), 16'(exp));
  endtask

  task automatic do_reset(input logic strap_n, input logic boot);
    host.strap(strap_n);
    boot_option_i <= boot;
    reset_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    host.strap(1'b1);
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    error_cnt++;
    final_report;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    sfr_wr_i = 1'b0;
    sfr_sel_i = 3'd0;
    sfr_wdata_i = 8'h00;
    ext_exec_i = 1'b0;
    code_rd_i = 1'b0;
    code_addr_i = 16'h0000;
    boot_option_i = 1'b0;
    do_reset(1'b1, 1'b0);
    chk(16'(serial_download_o), 16'h0000);
    chk(reset_vector_o, 16'h0000);
    host.op(2'b11, 6'b000100, 16'h0000, 8'h00, rf, rdv);
    // data flash page round trip
    page(16'h0003);
    wr(3'd0, `FMAC_CMD_ERASE_PAGE);
    wr(3'd0, `FMAC_CMD_READ);
    for (int i = 1; i <= 4; i++) rd(3'(i), `FMAC_ERASED);
    for (int i = 1; i <= 4; i++) wr(3'(i), 8'(8'h11 * i));
    wr(3'd0, `FMAC_CMD_WRITE);
    for (int i = 1; i <= 4; i++) wr(3'(i), 8'h00);
    wr(3'd0, `FMAC_CMD_READ);
    for (int i = 1; i <= 4; i++) rd(3'(i), 8'(8'h11 * i));
    wr(3'd0, `FMAC_CMD_VERIFY);
    rd(3'd0, 8'h00);
    wr(3'd2, 8'h5A);
    wr(3'd0, `FMAC_CMD_VERIFY);
    rd(3'd0, `FMAC_VERIFY_BAD);
    wr(3'd0, 8'h03);
    rd(3'd2, 8'h5A);
    wr(3'd0, `FMAC_CMD_READ);
    rd(3'd2, 8'h22);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    wr(3'd2, 8'h99);
    clk_en_i <= 1'b1;
    rd(3'd2, 8'h22);
    page(16'h000D);
    wr(3'd0, `FMAC_CMD_READ_BYTE);
    rd(3'd1, 8'h22);
    // byte write into page four
    page(16'h0004);
    wr(3'd0, `FMAC_CMD_ERASE_PAGE);
    page(16'h0011);
    wr(3'd1, 8'h77);
    wr(3'd0, `FMAC_CMD_WRITE_BYTE);
    page(16'h0004);
    wr(3'd0, `FMAC_CMD_READ);
    rd(3'd2, 8'h77);
    rd(3'd1, `FMAC_ERASED);
    wr(3'd0, `FMAC_CMD_ERASE_ALL);
    page(16'h0003);
    wr(3'd0, `FMAC_CMD_READ);
    rd(3'd3, `FMAC_ERASED);
    // program flash through user download mode
    wr(3'd0, `FMAC_CMD_ENTER_ULD);
    chk(16'(user_download_mode_o), 16'h0001);
    page(16'h0100);
    wr(3'd1, 8'h3C);
    wr(3'd0, `FMAC_CMD_WRITE_BYTE);
    crd(16'h0100, 1'b0, 8'h3C, 1'b0);
    wr(3'd0, `FMAC_CMD_ERASE_PAGE);
    crd(16'h0100, 1'b0, `FMAC_ERASED, 1'b0);
    wr(3'd1, 8'hA5);
    wr(3'd0, `FMAC_CMD_WRITE_BYTE);
    crd(16'h0100, 1'b0, 8'hA5, 1'b0);
    page(16'hE000);
    wr(3'd0, `FMAC_CMD_WRITE_BYTE);
    crd(16'hE000, 1'b0, `FMAC_ERASED, 1'b0);
    wr(3'd0, `FMAC_CMD_LEAVE_ULD);
    chk(16'(user_download_mode_o), 16'h0000);
    page(16'h0100);
    wr(3'd1, 8'h00);
    wr(3'd0, `FMAC_CMD_WRITE_BYTE);
    crd(16'h0100, 1'b0, 8'hA5, 1'b0);
    // security modes
    host.op(2'b11, 6'b001000, 16'h0000, 8'h00, rf, rdv);
    chk(16'(lock_mode_o), 16'h0001);
    host.op(2'b11, 6'b000001, 16'h0100, 8'h00, rf, rdv);
    chk(16'(rf), 16'h0001);
    host.op(2'b11, 6'b000010, 16'h0100, 8'h00, rf, rdv);
    chk({7'd0, rf, rdv}, 16'h00A5);
    crd(16'h0100, 1'b1, 8'hA5, 1'b0);
    host.op(2'b11, 6'b010000, 16'h0000, 8'h00, rf, rdv);
    chk(16'(secure_mode_o), 16'h0001);
    host.op(2'b11, 6'b000010, 16'h0100, 8'h00, rf, rdv);
    chk(16'(rf), 16'h0001);
    crd(16'h0100, 1'b1, 8'hA5, 1'b1);
    host.op(2'b11, 6'b100000, 16'h0000, 8'h00, rf, rdv);
    do_reset(1'b0, 1'b1);
    chk(16'(serial_download_o), 16'h0000);
    chk(reset_vector_o, `FMAC_BOOT_VECTOR);
    chk({13'd0, lock_mode_o, secure_mode_o, serial_safe_o}, 16'h0007);
    host.op(2'b11, 6'b000100, 16'h0000, 8'h00, rf, rdv);
    chk({13'd0, lock_mode_o, secure_mode_o, serial_safe_o}, 16'h0000);
    do_reset(1'b0, 1'b0);
    chk(16'(serial_download_o), 16'h0001);
    host.op(2'b01, 6'b000001, 16'hE000, 8'h3C, rf, rdv);
    host.op(2'b01, 6'b000010, 16'hE000, 8'h00, rf, rdv);
    chk(16'(rdv), 16'h003C);
    final_report;
  end
endmodule
